// *** rtl/msp_protect.sv ***
// Purpose: motor status, stall stage, phase sequence stage, fault log
// Assumes: currents are sampled values scaled 256 = motor nominal
// Notes:   inverse delay is operate = multiplier * (nominal start / I)^2
`timescale 1ns/1ns
module msp_protect
  import msp_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int LOG_N       = LOG_DEPTH
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // measured values
  input  wire logic [15:0] avg_current,
  input  wire logic [15:0] max_current,
  input  wire logic [15:0] neg_pos_sequence_ratio,
  // stall settings
  input  wire logic        detect_level_wr,
  input  wire logic [15:0] detect_level_in,
  input  wire logic [15:0] nominal_starting_current,
  input  wire logic        definite_characteristic,
  input  wire logic [15:0] definite_operate_time,
  input  wire logic [15:0] inverse_time_multiplier,
  // unbalance fault log input
  input  wire logic        unb_fault,
  input  wire logic [47:0] unb_stamp,
  input  wire logic [15:0] unb_max,
  input  wire logic [7:0]  unb_delay_pct,
  input  wire logic        active_setting_group,
  input  wire logic [2:0]  log_sel,
  // motor status
  output logic             motor_stopped,
  output logic             motor_starting,
  output logic             motor_running,
  output logic [15:0]      detect_level,
  // phase sequence stage
  output logic             seq_start,
  output logic             seq_trip,
  output logic [15:0]      seq_start_counter,
  output logic [15:0]      seq_trip_counter,
  output logic [15:0]      seq_fault_max,
  output logic [7:0]       seq_delay_pct,
  // stall stage
  output logic             stall_start,
  output logic             stall_trip,
  output logic [15:0]      stall_start_counter,
  output logic [15:0]      stall_trip_counter,
  output logic [15:0]      stall_fault_max,
  output logic [7:0]       stall_delay_pct,
  // fault log read port
  output logic [47:0]      log_stamp,
  output logic [15:0]      log_max,
  output logic [7:0]       log_delay_pct,
  output logic [1:0]       log_group,
  output logic [3:0]       log_count
);
  //////////////////////////////////////////////////////////////////////////
  // millisecond tick
  logic [23:0] tick_cnt_q;
  logic        tick;
  assign tick = (tick_cnt_q == 24'(TICK_CYCLES - 1));

  // free running divider for every timer in the block
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) tick_cnt_q <= 24'h000000;
    else if (tick) tick_cnt_q <= 24'h000000;
    else tick_cnt_q <= tick_cnt_q + 24'h000001;
  end

  //////////////////////////////////////////////////////////////////////////
  // start detection level setting
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) detect_level <= LVL_DETECT_RST;
    else if (detect_level_wr) detect_level <= detect_level_in;
  end

  // a configuration write lands on the next edge
  det_wr_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    detect_level_wr |=> detect_level == $past(detect_level_in))
    else $error("detection level write lost");

  //////////////////////////////////////////////////////////////////////////
  // motor status
  msp_state_t  state_q;
  logic [15:0] stop_ms_q;
  logic [15:0] rise_ms_q;
  logic        armed_q;
  logic        below_stop;
  logic        in_run;
  logic        above_det;

  assign below_stop = avg_current < LVL_STOP;
  assign in_run = (avg_current >= LVL_RUN_LO) && (avg_current <= LVL_RUN_HI);
  assign above_det = avg_current > detect_level;

  // time spent stopped, saturating
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) stop_ms_q <= 16'h0000;
    else if (!below_stop) stop_ms_q <= 16'h0000;
    else if (tick && stop_ms_q != 16'hFFFF) stop_ms_q <= stop_ms_q + 16'h0001;
  end

  // rise window opens when current leaves the stopped band
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_q   <= 1'b0;
      rise_ms_q <= 16'h0000;
    end else if (below_stop) begin
      armed_q   <= stop_ms_q >= STOP_HOLD_MS;
      rise_ms_q <= 16'h0000;
    end else if (tick && armed_q) begin
      if (rise_ms_q >= RISE_WIN_MS) armed_q <= 1'b0;
      else rise_ms_q <= rise_ms_q + 16'h0001;
    end
  end

  // arming needs the full stopped time behind it
  arm_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $rose(armed_q) |-> $past(stop_ms_q) >= STOP_HOLD_MS)
    else $error("start armed before stopped time");

  win_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    armed_q |-> rise_ms_q <= RISE_WIN_MS)
    else $error("rise window overran");

  // stopped has priority; starting holds until the running band is reached
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) state_q <= MSP_STOPPED;
    else begin
      case (state_q)
        MSP_STOPPED: begin
          if (!below_stop && armed_q && above_det)
            state_q <= MSP_STARTING;
          else if (in_run) state_q <= MSP_RUNNING;
        end
        MSP_STARTING: begin
          if (below_stop) state_q <= MSP_STOPPED;
          else if (in_run) state_q <= MSP_RUNNING;
        end
        MSP_RUNNING: begin
          if (below_stop) state_q <= MSP_STOPPED;
        end
        default: state_q <= MSP_STOPPED;
      endcase
    end
  end

  assign motor_stopped  = state_q == MSP_STOPPED;
  assign motor_starting = state_q == MSP_STARTING;
  assign motor_running  = state_q == MSP_RUNNING;

  //////////////////////////////////////////////////////////////////////////
  // phase sequence stage
  logic [15:0] seq_ms_q;
  logic        seq_over;
  assign seq_over = neg_pos_sequence_ratio > SEQ_PICKUP;

  // persistence timer; trip after the full delay
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) seq_ms_q <= 16'h0000;
    else if (!seq_over) seq_ms_q <= 16'h0000;
    else if (tick && seq_ms_q < SEQ_DELAY_MS) seq_ms_q <= seq_ms_q + 16'h0001;
  end

  // the persistence timer restarts whenever the ratio drops back
  seq_rst_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !seq_over |=> seq_ms_q == 16'h0000)
    else $error("sequence timer kept time after drop");

  assign seq_start = seq_over;
  assign seq_trip  = seq_over && (seq_ms_q >= SEQ_DELAY_MS);

  msp_stage_if seq_if ();
  assign seq_if.start = seq_start;
  assign seq_if.trip  = seq_trip;
  assign seq_if.level = neg_pos_sequence_ratio;
  assign seq_if.pct   = 8'(seq_ms_q); // 100 ms is 100%

  msp_recorder u_seq_rec (
    .clk                   (clk),
    .sys_rst               (sys_rst),
    .st                    (seq_if.rec),
    .start_counter         (seq_start_counter),
    .trip_counter          (seq_trip_counter),
    .fault_max             (seq_fault_max),
    .elapsed_delay_percent (seq_delay_pct)
  );

  seq_trip_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $rose(seq_trip) |-> seq_start && seq_ms_q == SEQ_DELAY_MS)
    else $error("phase sequence trip without full delay");

  //////////////////////////////////////////////////////////////////////////
  // stall stage: active only while starting, accumulates in 1/256 ms
  logic        stall_q;
  logic [31:0] acc_q;
  logic [31:0] op_time;
  logic [31:0] ratio;
  logic [31:0] acc_next;
  logic        stall_release;

  // ratio = (nominal start / measured)^2 in 1/256 units
  always_comb begin
    ratio = 32'h00000000;
    if (max_current != 16'h0000)
      ratio = (32'(nominal_starting_current) << 8) / 32'(max_current);
    ratio = (ratio * ratio) >> 8;
  end

  // operate time in ms scaled by 256
  always_comb begin
    if (definite_characteristic)
      op_time = 32'(definite_operate_time) << 8;
    else
      op_time = 32'((64'(inverse_time_multiplier) * 64'(ratio)) >> 0);
  end

  assign stall_release = max_current < LVL_RUN_HI;
  assign acc_next = acc_q + 32'h00000100;

  // start when the status logic declares a genuine start
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stall_q <= 1'b0;
      acc_q   <= 32'h00000000;
    end else if (!motor_starting || stall_release) begin
      stall_q <= 1'b0;
      acc_q   <= 32'h00000000;
    end else begin
      stall_q <= 1'b1;
      if (tick && stall_q && acc_q < op_time) acc_q <= acc_next;
    end
  end

  assign stall_start = stall_q;
  assign stall_trip  = stall_q && (acc_q >= op_time);

  msp_stage_if stall_if ();
  logic [31:0] stall_pct;
  assign stall_pct = (op_time == 32'h00000000) ? 32'(PCT_FULL) :
                     32'((64'(acc_q) * 64'(PCT_FULL)) / 64'(op_time));
  assign stall_if.start = stall_start;
  assign stall_if.trip  = stall_trip;
  assign stall_if.level = max_current;
  assign stall_if.pct   = (stall_pct > 32'(PCT_FULL)) ? PCT_FULL :
                          stall_pct[7:0];

  // a stall trip always reads as the full delay
  stall_pct_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    stall_trip |-> stall_if.pct == PCT_FULL)
    else $error("stall trip without full elapsed delay");

  msp_recorder u_stall_rec (
    .clk                   (clk),
    .sys_rst               (sys_rst),
    .st                    (stall_if.rec),
    .start_counter         (stall_start_counter),
    .trip_counter          (stall_trip_counter),
    .fault_max             (stall_fault_max),
    .elapsed_delay_percent (stall_delay_pct)
  );

  stall_inert_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !motor_starting |=> !stall_start)
    else $error("stall stage active outside starting");

  stall_rel_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (stall_start && max_current < LVL_RUN_HI) |=> !stall_start)
    else $error("stall did not release at low current");

  //////////////////////////////////////////////////////////////////////////
  // unbalance fault log, circular, newest at log_sel 0
  logic [47:0] stamp_mem [LOG_N];
  logic [15:0] max_mem   [LOG_N];
  logic [7:0]  dly_mem   [LOG_N];
  logic        grp_mem   [LOG_N];
  logic [2:0]  wr_ptr_q;
  logic [2:0]  rd_idx;

  // store one entry per fault and advance
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_q  <= 3'h0;
      log_count <= 4'h0;
    end else if (unb_fault) begin
      wr_ptr_q <= wr_ptr_q + 3'h1;
      if (log_count != 4'(LOG_N)) log_count <= log_count + 4'h1;
    end
  end

  // array holds no reset; count tells which entries are valid
  always_ff @(posedge clk) begin
    if (unb_fault) begin
      stamp_mem[wr_ptr_q] <= unb_stamp;
      max_mem[wr_ptr_q]   <= unb_max;
      dly_mem[wr_ptr_q]   <= unb_delay_pct;
      grp_mem[wr_ptr_q]   <= active_setting_group;
    end
  end

  assign rd_idx = wr_ptr_q - 3'h1 - log_sel;

  // registered read; group shown as 1 or 2, or 0 for a slot past log_count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      log_stamp     <= 48'h000000000000;
      log_max       <= 16'h0000;
      log_delay_pct <= 8'h00;
      log_group     <= 2'h0;
    end else if ({1'b0, log_sel} < log_count) begin
      log_stamp     <= stamp_mem[rd_idx];
      log_max       <= max_mem[rd_idx];
      log_delay_pct <= dly_mem[rd_idx];
      log_group     <= grp_mem[rd_idx] ? 2'h2 : 2'h1;
    end else begin
      log_stamp     <= 48'h000000000000;
      log_max       <= 16'h0000;
      log_delay_pct <= 8'h00;
      log_group     <= 2'h0;
    end
  end

  // status transitions and log bookkeeping
  stop_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    below_stop |=> motor_stopped)
    else $error("motor not stopped at low current");
  run_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (motor_stopped && in_run && !(armed_q && above_det)) |=> motor_running)
    else $error("running not entered from stopped");
  run_hold_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (motor_running && !below_stop) |=> motor_running)
    else $error("running state left above stopped level");
  startok_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $rose(motor_starting) |-> $past(armed_q) && $past(above_det))
    else $error("starting entered without a qualified rise");
  hold_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (motor_starting && !below_stop && !in_run) |=> motor_starting)
    else $error("starting state left early");
  cnt_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    log_count <= 4'(LOG_N))
    else $error("fault log count overflow");
endmodule : msp_protect

// *** rtl/msp_pkg.sv ***
// Purpose: constants for the motor status, stall and phase sequence block
// Assumes: currents are unsigned fixed point, 1/256 of motor nominal
// Notes:   ratios are in percent; times count in milliseconds
package msp_pkg;
  localparam int          CLK_HZ        = 125000000;
  localparam int          TICK_NS       = 1000000;
  localparam int          CLK_NS        = 8;
  localparam int          TICK_CYC      = TICK_NS / CLK_NS;
  localparam int          CW            = 16;
  localparam logic [15:0] NOM_ONE       = 16'h0100;
  localparam logic [15:0] LVL_STOP      = 16'h001A; // about 10%
  localparam logic [15:0] LVL_RUN_LO    = 16'h0033; // about 20%
  localparam logic [15:0] LVL_RUN_HI    = 16'h0133; // about 120%
  localparam logic [15:0] LVL_DETECT_RST = 16'h0600; // six times nominal
  localparam logic [15:0] SEQ_PICKUP    = 16'h0050; // 80 percent
  localparam logic [15:0] SEQ_DELAY_MS  = 16'h0064; // 100 ms
  localparam logic [15:0] RISE_WIN_MS   = 16'h00C8; // 200 ms
  localparam logic [15:0] STOP_HOLD_MS  = 16'h01F4; // 500 ms
  localparam logic [7:0]  PCT_FULL      = 8'h64;
  localparam int          LOG_DEPTH     = 8;
  typedef enum logic [1:0] {MSP_STOPPED, MSP_STARTING, MSP_RUNNING}
    msp_state_t;
endpackage : msp_pkg

// *** rtl/msp_stage_if.sv ***
// Purpose: carries one stage's start/trip and delay between modules
// Assumes: single clock domain
// Notes:   recorder watches what the stage drives
`timescale 1ns/1ns
interface msp_stage_if;
  logic        start;
  logic        trip;
  logic [15:0] level;
  logic [7:0]  pct;
  modport stage (output start, trip, level, pct);
  modport rec   (input start, trip, level, pct);
endinterface : msp_stage_if

// *** rtl/msp_recorder.sv ***
// Purpose: counters, fault maximum and elapsed delay record per stage
// Assumes: start rises before or with trip
// Notes:   counters wrap silently
`timescale 1ns/1ns
module msp_recorder
  import msp_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // watched stage
  msp_stage_if.rec         st,
  // records
  output logic [15:0]      start_counter,
  output logic [15:0]      trip_counter,
  output logic [15:0]      fault_max,
  output logic [7:0]       elapsed_delay_percent
);
  logic start_q;
  logic trip_q;

  // edge memory for counting events once
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_q <= 1'b0;
      trip_q  <= 1'b0;
    end else begin
      start_q <= st.start;
      trip_q  <= st.trip;
    end
  end

  // cumulative counters
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_counter <= 16'h0000;
      trip_counter  <= 16'h0000;
    end else begin
      if (st.start && !start_q)
        start_counter <= start_counter + 16'h0001;
      if (st.trip && !trip_q)
        trip_counter <= trip_counter + 16'h0001;
    end
  end

  // fault maximum and delay both restart at each new start, then keep the peak
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_max             <= 16'h0000;
      elapsed_delay_percent <= 8'h00;
    end else if (st.start) begin
      if (!start_q) begin
        fault_max             <= st.level;
        elapsed_delay_percent <= st.pct;
      end else begin
        if (st.level > fault_max) fault_max <= st.level;
        if (st.pct > elapsed_delay_percent)
          elapsed_delay_percent <= st.pct;
      end
    end
  end

  tcnt_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (st.trip && !trip_q) |=> trip_counter == $past(trip_counter) + 16'h0001)
    else $error("trip counter missed a trip");
endmodule : msp_recorder

// *** tb/msp_source.sv ***
// Purpose: upstream measurement model, feeds currents and sequence ratio
// Assumes: commands change just after rising edges
// Notes:   one clock of latency, like a sampled measurement chain
`timescale 1ns/1ns
module msp_source (
  // clock
  input  wire logic        clk,
  // commanded values
  input  wire logic [15:0] cur_cmd,
  input  wire logic [15:0] ratio_cmd,
  // measured values
  output logic      [15:0] avg_current,
  output logic      [15:0] max_current,
  output logic      [15:0] neg_pos_sequence_ratio
);
  ////////////////////////////////////////////////////////////////////////////
  // worst phase sits a little above the average, as in a real motor
  always_ff @(posedge clk) begin
    avg_current            <= cur_cmd;
    max_current            <= cur_cmd + 16'h0010;
    neg_pos_sequence_ratio <= ratio_cmd;
  end
endmodule : msp_source

// *** tb/motor_stall_status_protect_tb.sv ***
// Purpose: self-checking bench for the motor status and protection block
// Assumes: millisecond tick shortened to a few clocks
// Notes:   all timing expectations derive from the shortened tick
`timescale 1ns/1ns
module motor_stall_status_protect_tb;
  import msp_pkg::*;
  localparam int TK = 10; // clocks per simulated millisecond
  logic clk, sys_rst, lvl_wr, def_sel, unb_fault, grp, saw_start;
  logic [15:0] cur, ratio, avg, mx, npr, lvl_in, nom_st, op_def, op_inv;
  logic [15:0] unb_max;
  logic [47:0] unb_stamp;
  logic [7:0]  unb_pct;
  logic [2:0]  log_sel;
  logic mstop, mstart, mrun, sq_s, sq_t, st_s, st_t;
  logic [15:0] lvl, sq_sc, sq_tc, sq_fm, st_sc, st_tc, st_fm;
  logic [7:0]  sq_pct, st_pct, lg_pct;
  logic [47:0] lg_stamp;
  logic [15:0] lg_max;
  logic [1:0]  lg_grp;
  logic [3:0]  lg_cnt;
  int errors, compares, nstall;
  ////////////////////////////////////////////////////////////////////////////
  msp_source src_u (.clk(clk), .cur_cmd(cur), .ratio_cmd(ratio),
    .avg_current(avg), .max_current(mx), .neg_pos_sequence_ratio(npr));
  msp_protect #(.TICK_CYCLES(TK)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .avg_current(avg), .max_current(mx), .neg_pos_sequence_ratio(npr),
    .detect_level_wr(lvl_wr), .detect_level_in(lvl_in),
    .nominal_starting_current(nom_st), .definite_characteristic(def_sel),
    .definite_operate_time(op_def), .inverse_time_multiplier(op_inv),
    .unb_fault(unb_fault), .unb_stamp(unb_stamp), .unb_max(unb_max),
    .unb_delay_pct(unb_pct), .active_setting_group(grp),
    .log_sel(log_sel), .motor_stopped(mstop), .motor_starting(mstart),
    .motor_running(mrun), .detect_level(lvl), .seq_start(sq_s),
    .seq_trip(sq_t), .seq_start_counter(sq_sc), .seq_trip_counter(sq_tc),
    .seq_fault_max(sq_fm), .seq_delay_pct(sq_pct), .stall_start(st_s),
    .stall_trip(st_t), .stall_start_counter(st_sc),
    .stall_trip_counter(st_tc), .stall_fault_max(st_fm),
    .stall_delay_pct(st_pct), .log_stamp(lg_stamp), .log_max(lg_max),
    .log_delay_pct(lg_pct), .log_group(lg_grp), .log_count(lg_cnt));
  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic wait_ms(input int n);
    repeat (n * TK) @(posedge clk);
  endtask : wait_ms
  // wait n ms, noting whether the starting state ever showed
  task automatic watch_ms(input int n, output logic seen);
    seen = 1'b0;
    repeat (n * TK) begin
      @(posedge clk);
      if (mstart === 1'b1) seen = 1'b1;
    end
  endtask : watch_ms
  ////////////////////////////////////////////////////////////////////////////
  // phase sequence: boundary ratio, then pickup, 100 ms trip and records
  task automatic t_seq();
    ratio <= 16'h0050;
    repeat (3) @(posedge clk);
    check(sq_s, 1'b0);
    ratio <= 16'h0051;
    repeat (3) @(posedge clk);
    check(sq_s, 1'b1);
    check(sq_sc, 16'h0001);
    wait_ms(97);
    check(sq_t, 1'b0);
    wait_ms(5);
    check(sq_t, 1'b1);
    check(sq_tc, 16'h0001);
    check(sq_fm, 16'h0051);
    check(sq_pct, PCT_FULL);
    ratio <= 16'h0000;
    repeat (3) @(posedge clk);
    check(sq_s, 1'b0);
  endtask : t_seq
  // soft start never reaches the detection level, so no starting state
  task automatic t_soft();
    wait_ms(600);
    cur <= 16'h0100;
    watch_ms(250, saw_start);
    check(mrun, 1'b1);
    check(saw_start, 1'b0);
    check(st_s, 1'b0);
    cur <= 16'h0000;
    repeat (3) @(posedge clk);
    check(mstop, 1'b1);
  endtask : t_soft
  // a short stop, or a rise slower than 200 ms, must not qualify a start
  task automatic t_short();
    cur <= 16'h0100;
    wait_ms(20);
    cur <= 16'h0000;
    wait_ms(100);
    cur <= 16'h0700;
    watch_ms(50, saw_start);
    check(saw_start, 1'b0);
    check(st_s, 1'b0);
    cur <= 16'h0000;
    wait_ms(600);
    cur <= 16'h0200;
    wait_ms(250);
    cur <= 16'h0700;
    watch_ms(50, saw_start);
    check(saw_start, 1'b0);
    check(st_s, 1'b0);
  endtask : t_short
  // full start: stop, rise above detection, time the stall, then release
  task automatic stall_run(input logic [15:0] cv, input logic defn,
                           input logic [15:0] op, input int lo, hi);
    int n;
    n = 0;
    cur <= 16'h0000;
    def_sel <= defn;
    op_def <= op;
    op_inv <= op;
    wait_ms(600);
    cur <= cv;
    nstall++;
    while (st_t !== 1'b1 && n < 400) begin
      wait_ms(1);
      n++;
    end
    if (n >= 400) begin
      errors++;
      results();
    end
    check(mstart, 1'b1);
    check(st_s, 1'b1);
    check(n >= lo && n <= hi, 1'b1);
    check(st_pct, PCT_FULL);
    check(st_sc, nstall[15:0]);
    check(st_tc, nstall[15:0]);
    check(st_fm, cv + 16'h0010);
    cur <= 16'h0100;
    repeat (3) @(posedge clk);
    check(st_s, 1'b0);
    check(mrun, 1'b1);
  endtask : stall_run
  task automatic t_stall();
    nom_st <= 16'h0800;
    stall_run(16'h0700, 1'b1, 16'h0032, 48, 53);
    stall_run(16'h0700, 1'b0, 16'h0064, 122, 134);
    stall_run(16'h0A00, 1'b0, 16'h0064, 59, 67);
    lvl_in <= 16'h0400;
    lvl_wr <= 1'b1;
    @(posedge clk);
    lvl_wr <= 1'b0;
    @(posedge clk);
    check(lvl, 16'h0400);
    stall_run(16'h0500, 1'b1, 16'h0014, 18, 23);
  endtask : t_stall
  // nine faults into an eight-deep log: oldest one falls out
  task automatic t_log();
    for (int i = 1; i <= 9; i++) begin
      unb_stamp <= 48'(i);
      unb_max <= 16'h0100 + 16'(i);
      unb_pct <= 8'(i * 10);
      grp <= i[0];
      unb_fault <= 1'b1;
      @(posedge clk);
      unb_fault <= 1'b0;
      @(posedge clk);
    end
    check(lg_cnt, 4'h8);
    log_sel <= 3'h0;
    repeat (2) @(posedge clk);
    check(lg_stamp, 48'h9);
    check(lg_max, 16'h0109);
    check(lg_grp, 2'h2);
    log_sel <= 3'h7;
    repeat (2) @(posedge clk);
    check(lg_stamp, 48'h2);
    check(lg_pct, 8'h14);
    check(lg_grp, 2'h1);
  endtask : t_log
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    errors = 0;
    compares = 0;
    nstall = 0;
    saw_start = 1'b0;
    sys_rst = 1'b1;
    {cur, ratio, lvl_in, nom_st, op_def, op_inv, unb_max} = '0;
    {lvl_wr, def_sel, unb_fault, grp, unb_stamp, unb_pct, log_sel} = '0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check(lvl, 16'h0600);
    check(mstop, 1'b1);
    check(lg_cnt, 4'h0);
    t_seq();
    t_soft();
    t_short();
    t_stall();
    t_log();
    results();
  end
endmodule : motor_stall_status_protect_tb
